// ### verilog/dsac_ctrl_host.sv
// Controller end: clock divider, command sequencer, data pins, refresh scaling.
`timescale 1ns/1ns
module dsac_ctrl_host #(
  parameter int ROW_W = dsac_pkg::ROW_W_X8,
  parameter int REFI_TICKS = dsac_pkg::REFI_TICKS
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic REQ_VALID_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic [dsac_pkg::BA_W-1:0] REQ_BANK_IN,
  input wire logic [ROW_W-1:0] REQ_ROW_IN,
  input wire logic [dsac_pkg::COL_W-1:0] REQ_COL_IN,
  input wire logic REQ_CHOP_IN,
  input wire logic REQ_AP_IN,
  input wire logic [8*dsac_pkg::DQ_W-1:0] REQ_WDATA_IN,
  input wire logic [1:0] TEMP_GRADE_IN,
  input wire logic [7:0] TEMP_C_IN,
  output logic REQ_READY_OUT,
  output logic RD_VALID_OUT,
  output logic [8*dsac_pkg::DQ_W-1:0] RD_DATA_OUT,
  output logic [3:0] REF_MULT_OUT,
  output logic HI_TEMP_SR_OUT,
  output logic SELF_REF_OK_OUT,
  dsac_link_if.host LINK
);

  localparam int DW = dsac_pkg::DQ_W;
  localparam int AW = dsac_pkg::ADDR_W;
  localparam logic [7:0] WR_PRE = 8'(4 * dsac_pkg::CAS_WR_LAT - 4);
  localparam logic [7:0] WR_BEG = 8'(4 * dsac_pkg::CAS_WR_LAT);
  localparam logic [7:0] RD_BEG = 8'(4 * dsac_pkg::CAS_LAT + 6);
  localparam logic [7:0] LC_END = 8'(dsac_pkg::XFER_END);
  localparam logic [7:0] REFI = 8'(REFI_TICKS);
  localparam logic [1:0] BOOT = 2'(dsac_pkg::BOOT_TICKS);

  typedef enum logic [2:0] {
    H_MRS = 3'b000,
    H_PREA = 3'b001,
    H_IDLE = 3'b010,
    H_ACC = 3'b011,
    H_XFER = 3'b100
  } dsac_hstate_t;

  typedef struct packed {
    dsac_hstate_t state;
    logic [1:0] boot;
    logic [1:0] ph;
    logic ck;
    logic ck_n;
    logic cke;
    dsac_pkg::dsac_cmd_t cmd;
    logic [dsac_pkg::BA_W-1:0] ba;
    logic [AW-1:0] addr;
    logic pend;
    logic ready;
    logic wr;
    logic [dsac_pkg::BA_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [dsac_pkg::COL_W-1:0] col;
    logic chop;
    logic ap;
    logic [8*DW-1:0] wdata;
    logic [7:0] lc;
    logic [DW-1:0] dq_o;
    logic dq_oe_n;
    logic dqs_o;
    logic dqs_oe_n;
    logic [DW-1:0] s1;
    logic [DW-1:0] s2;
    logic [DW-1:0] s3;
    logic [DW-1:0] filt;
    logic [8*DW-1:0] rdata;
    logic rd_valid;
    logic [7:0] refcnt;
    logic ref_due;
    logic [3:0] mult;
    logic htsr;
    logic sr_ok;
  } dsac_host_t;

  dsac_host_t st_q;
  dsac_host_t st_d;
  logic tick;
  logic [7:0] span;
  logic [7:0] rr;
  logic [7:0] wb;
  logic [7:0] limit;

  assign tick = (st_q.ph == 2'h3);
  assign span = st_q.chop ? 8'h08 : 8'h10;
  assign rr = st_q.lc - RD_BEG;
  assign wb = st_q.lc - WR_BEG;

  always_comb begin
    case (st_q.mult)
      4'h8: limit = REFI >> 3;
      4'h4: limit = REFI >> 2;
      4'h2: limit = REFI >> 1;
      default: limit = REFI;
    endcase
  end

  always_comb begin
    st_d = st_q;
    // Link clock is the reference clock divided by four.
    st_d.ph = st_q.ph + 2'h1;
    st_d.ck = st_d.ph[1];
    st_d.ck_n = ~st_d.ph[1];
    st_d.cke = 1'b1;
    st_d.rd_valid = 1'b0;
    // Read data comes from another domain: three stages, taken once two agree.
    st_d.s1 = LINK.dq;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.filt = st_q.s3;
    end
    // Refresh rate scaling by grade and case temperature.
    st_d.mult = 4'h1;
    if (TEMP_GRADE_IN == dsac_pkg::GRADE_UT) begin
      if (TEMP_C_IN > dsac_pkg::TEMP_8X_C) begin
        st_d.mult = 4'h8;
      end else if (TEMP_C_IN > dsac_pkg::TEMP_4X_C) begin
        st_d.mult = 4'h4;
      end else if (TEMP_C_IN > dsac_pkg::TEMP_2X_C) begin
        st_d.mult = 4'h2;
      end
    end else if (TEMP_C_IN > dsac_pkg::TEMP_2X_C) begin
      st_d.mult = 4'h2;
    end
    st_d.htsr = (TEMP_GRADE_IN == dsac_pkg::GRADE_IT) && (TEMP_C_IN > dsac_pkg::TEMP_2X_C);
    st_d.sr_ok = !((TEMP_GRADE_IN == dsac_pkg::GRADE_UT) && (TEMP_C_IN > dsac_pkg::TEMP_4X_C));
    if (REQ_VALID_IN && st_q.ready) begin
      st_d.pend = 1'b1;
      st_d.wr = REQ_WRITE_IN;
      st_d.bank = REQ_BANK_IN;
      st_d.row = REQ_ROW_IN;
      st_d.col = REQ_COL_IN;
      st_d.chop = REQ_CHOP_IN;
      st_d.ap = REQ_AP_IN;
      st_d.wdata = REQ_WDATA_IN;
    end
    // Data pins during a transfer, paced by ref cycles since the command.
    st_d.dq_oe_n = 1'b1;
    st_d.dqs_oe_n = 1'b1;
    st_d.dqs_o = 1'b0;
    if (st_q.state == H_XFER) begin
      st_d.lc = st_q.lc + 8'h01;
      if (st_q.wr) begin
        st_d.dqs_oe_n = !(st_q.lc >= WR_PRE && st_q.lc < WR_BEG + span);
        st_d.dq_oe_n = !(st_q.lc >= WR_BEG && st_q.lc < WR_BEG + span);
        st_d.dqs_o = !st_d.dq_oe_n && st_d.ph[1];
        if (!st_d.dq_oe_n && !st_q.lc[0]) begin
          st_d.dq_o = st_q.wdata[wb[3:1]*DW +: DW];
        end
      end else if (st_q.lc >= RD_BEG && !rr[0] && rr < span) begin
        st_d.rdata[rr[3:1]*DW +: DW] = st_q.filt;
      end
    end
    if (tick) begin
      st_d.cmd = dsac_pkg::CMD_NOP;
      st_d.refcnt = st_q.refcnt + 8'h01;
      case (st_q.state)
        H_MRS: begin
          // The memory end leaves reset two link clocks late; an early mode load is lost.
          if (st_q.boot != BOOT) begin
            st_d.boot = st_q.boot + 2'h1;
          end else begin
            st_d.cmd = dsac_pkg::CMD_MRS;
            st_d.ba = '0;
            st_d.addr = AW'(dsac_pkg::BLM_OTF);
            st_d.state = H_PREA;
          end
        end
        H_PREA: begin
          st_d.cmd = dsac_pkg::CMD_PRE;
          st_d.addr = '0;
          st_d.addr[dsac_pkg::AP_BIT] = 1'b1;
          st_d.state = H_IDLE;
        end
        H_IDLE: begin
          if (st_q.ref_due) begin
            st_d.cmd = dsac_pkg::CMD_REF;
            st_d.ref_due = 1'b0;
          end else if (st_q.pend) begin
            st_d.cmd = dsac_pkg::CMD_ACT;
            st_d.ba = st_q.bank;
            st_d.addr = AW'(st_q.row);
            st_d.state = H_ACC;
          end
        end
        H_ACC: begin
          st_d.cmd = st_q.wr ? dsac_pkg::CMD_WR : dsac_pkg::CMD_RD;
          st_d.addr = AW'(st_q.col);
          st_d.addr[dsac_pkg::AP_BIT] = st_q.ap;
          st_d.addr[dsac_pkg::BC_BIT] = ~st_q.chop;
          st_d.lc = 8'h00;
          st_d.state = H_XFER;
        end
        H_XFER: begin
          if (st_q.lc >= LC_END) begin
            if (!st_q.ap) begin
              st_d.cmd = dsac_pkg::CMD_PRE;
              st_d.addr[dsac_pkg::AP_BIT] = 1'b0;
            end
            st_d.pend = 1'b0;
            st_d.rd_valid = !st_q.wr;
            st_d.state = H_IDLE;
          end
        end
        default: st_d.state = H_MRS;
      endcase
      // A refresh falling due wins over the clear in the same cycle.
      if (st_q.refcnt >= limit) begin
        st_d.refcnt = 8'h00;
        st_d.ref_due = 1'b1;
      end
    end
    st_d.ready = (st_d.state == H_IDLE) && !st_d.pend;
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q <= '0;
      st_q.cmd <= dsac_pkg::CMD_NOP;
      st_q.ck_n <= 1'b1;
      st_q.dq_oe_n <= 1'b1;
      st_q.dqs_oe_n <= 1'b1;
      st_q.sr_ok <= 1'b1;
      st_q.mult <= 4'h1;
    end else if (CLK_EN_IN) begin
      st_q <= st_d;
    end
  end

  assign LINK.ck = st_q.ck;
  assign LINK.ck_n = st_q.ck_n;
  assign LINK.cke = st_q.cke;
  assign LINK.cmd = st_q.cmd;
  assign LINK.ba = st_q.ba;
  assign LINK.addr = st_q.addr;
  assign LINK.dq_h = st_q.dq_o;
  assign LINK.dq_oe_n_h = st_q.dq_oe_n;
  assign LINK.dqs_h = st_q.dqs_o;
  assign LINK.dqs_oe_n_h = st_q.dqs_oe_n;
  assign REQ_READY_OUT = st_q.ready;
  assign RD_VALID_OUT = st_q.rd_valid;
  assign RD_DATA_OUT = st_q.rdata;
  assign REF_MULT_OUT = st_q.mult;
  assign HI_TEMP_SR_OUT = st_q.htsr;
  assign SELF_REF_OK_OUT = st_q.sr_ok;

endmodule : dsac_ctrl_host

// ### verilog/dsac_pkg.sv
// Shared constants, command codes and burst helpers for the DDR3 access core link.
package dsac_pkg;

  localparam int DQ_W = 8;
  localparam int BA_W = 3;
  localparam int NBANK = 8;
  localparam int ROW_W_X16 = 14;
  localparam int ROW_W_X8 = 15;
  localparam int ADDR_W = 15;
  localparam int COL_W = 10;
  localparam int BURST_LEN = 8;
  localparam int CAS_LAT = 3;
  localparam int CAS_WR_LAT = 2;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int NUM_MR = 4;

  // Burst length field of the first mode register, bits 1:0.
  localparam logic [1:0] BLM_FIX8 = 2'h0;
  localparam logic [1:0] BLM_OTF = 2'h1;
  localparam logic [1:0] BLM_FIX4 = 2'h2;
  localparam logic [ADDR_W-1:0] MR_RESET = 15'h0000;

  localparam logic [1:0] GRADE_IT = 2'h0;
  localparam logic [1:0] GRADE_AT = 2'h1;
  localparam logic [1:0] GRADE_UT = 2'h2;
  localparam logic [7:0] TEMP_2X_C = 8'h55;
  localparam logic [7:0] TEMP_4X_C = 8'h69;
  localparam logic [7:0] TEMP_8X_C = 8'h73;

  localparam int REF_CLK_NS = 40;
  localparam int CK_DIV = 4;
  localparam int REFI_NS = 7800;
  localparam int REFI_TICKS = REFI_NS / (REF_CLK_NS * CK_DIV);
  localparam int XFER_END = 4 * CAS_LAT + 24;
  // Link ticks the controller waits after reset so the memory end is awake first.
  localparam int BOOT_TICKS = 2;

  typedef enum logic [3:0] {
    CMD_MRS = 4'b0000,
    CMD_REF = 4'b0001,
    CMD_PRE = 4'b0010,
    CMD_ACT = 4'b0011,
    CMD_WR = 4'b0100,
    CMD_RD = 4'b0101,
    CMD_NOP = 4'b0111,
    CMD_DES = 4'b1000
  } dsac_cmd_t;

  // Sequential order, wrapping inside the eight or the chopped four.
  function automatic logic [2:0] burst_col(input logic [2:0] start, input logic [2:0] beat,
                                           input logic chop);
    logic [2:0] sum;
    sum = start + beat;
    burst_col = chop ? {start[2], sum[1:0]} : sum;
  endfunction : burst_col

endpackage : dsac_pkg

// ### verilog/dsac_link_if.sv
// Link between the memory controller end and the DDR3 memory end.
`timescale 1ns/1ns
interface dsac_link_if;
  logic ck;
  logic ck_n;
  logic cke;
  dsac_pkg::dsac_cmd_t cmd;
  logic [dsac_pkg::BA_W-1:0] ba;
  logic [dsac_pkg::ADDR_W-1:0] addr;
  logic [dsac_pkg::DQ_W-1:0] dq_h;
  logic [dsac_pkg::DQ_W-1:0] dq_d;
  logic [dsac_pkg::DQ_W-1:0] dq;
  logic dq_oe_n_h;
  logic dq_oe_n_d;
  logic dqs_h;
  logic dqs_d;
  logic dqs_oe_n_h;
  logic dqs_oe_n_d;
  logic dqs;
  logic dqs_n;

  // Resolved wire levels; an undriven bus reads as zero.
  assign dq = !dq_oe_n_h ? dq_h : (!dq_oe_n_d ? dq_d : '0);
  assign dqs = !dqs_oe_n_h ? dqs_h : (!dqs_oe_n_d ? dqs_d : 1'b0);
  assign dqs_n = ~dqs;

  modport host (output ck, ck_n, cke, cmd, ba, addr, dq_h, dq_oe_n_h, dqs_h, dqs_oe_n_h,
                input dq, dqs, dqs_n);
  modport dev (input ck, ck_n, cke, cmd, ba, addr, dq, dqs, dqs_n,
               output dq_d, dq_oe_n_d, dqs_d, dqs_oe_n_d);
endinterface : dsac_link_if

// ### verilog/dsac_mem_dev.sv
// Memory end: command decode, bank state, burst engines and a small data array.
`timescale 1ns/1ns
module dsac_mem_dev #(
  parameter int ROW_W = dsac_pkg::ROW_W_X8,
  parameter int ROW_KEEP = 1,
  parameter int COL_KEEP = 4
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CLK_EN_IN,
  dsac_link_if.dev LINK,
  output logic [dsac_pkg::NBANK-1:0] BANK_OPEN_OUT
);

  localparam int IDX_W = dsac_pkg::BA_W + ROW_KEEP + COL_KEEP;
  localparam int DEPTH = 1 << IDX_W;
  localparam logic [3:0] CL = 4'(dsac_pkg::CAS_LAT);
  localparam logic [3:0] CWL = 4'(dsac_pkg::CAS_WR_LAT);

  typedef struct packed {
    logic [dsac_pkg::NBANK-1:0] open;
    logic [dsac_pkg::NBANK-1:0][ROW_W-1:0] row;
    logic [dsac_pkg::NUM_MR-1:0][dsac_pkg::ADDR_W-1:0] mr;
    logic rd_busy;
    logic [3:0] rd_cnt;
    logic [dsac_pkg::BA_W-1:0] rd_ba;
    logic [COL_KEEP-1:0] rd_col;
    logic rd_chop;
    logic rd_ap;
    logic wr_busy;
    logic [3:0] wr_cnt;
    logic [dsac_pkg::BA_W-1:0] wr_ba;
    logic [COL_KEEP-1:0] wr_col;
    logic wr_chop;
    logic wr_ap;
  } dsac_dev_t;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Array index of one beat: bank, low row bits, column with burst wrap.
  function automatic logic [IDX_W-1:0] mem_idx(input logic [dsac_pkg::BA_W-1:0] ba,
                                               input logic [ROW_W-1:0] row,
                                               input logic [COL_KEEP-1:0] col,
                                               input logic [2:0] beat,
                                               input logic chop);
    mem_idx = {ba, row[ROW_KEEP-1:0], col[COL_KEEP-1:3],
               dsac_pkg::burst_col(col[2:0], beat, chop)};
  endfunction : mem_idx

  // Link clock cycles per burst: four for eight beats, two when chopped.
  function automatic logic [3:0] burst_cycles(input logic chop);
    burst_cycles = chop ? 4'h2 : 4'h4;
  endfunction : burst_cycles

  //////////////////////////////////////////////////////////////////////////////
  // Reset release on the link clock.

  logic [1:0] rst_sync_q;
  logic link_rst_n;

  always_ff @(posedge LINK.ck or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign link_rst_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // State and decode.

  dsac_dev_t st_q;
  dsac_dev_t st_d;
  logic chop_sel;
  logic [3:0] rd_nc;
  logic [3:0] wr_nc;
  logic [3:0] rd_j;
  logic [3:0] wr_je;
  logic [3:0] wr_jo;
  logic rd_pre;
  logic rd_data;
  logic wr_even_en;
  logic wr_odd_en;
  logic [IDX_W-1:0] rd_idx_e;
  logic [IDX_W-1:0] rd_idx_o;
  logic [IDX_W-1:0] wr_idx_e;
  logic [IDX_W-1:0] wr_idx_o;
  logic [dsac_pkg::DQ_W-1:0] dq_neg_q;
  logic [dsac_pkg::DQ_W-1:0] mem_q [DEPTH];

  // Chop choice follows the burst length field; on-the-fly uses address bit 12.
  always_comb begin
    case (st_q.mr[0][1:0])
      dsac_pkg::BLM_FIX4: chop_sel = 1'b1;
      dsac_pkg::BLM_OTF: chop_sel = ~LINK.addr[dsac_pkg::BC_BIT];
      default: chop_sel = 1'b0;
    endcase
  end

  assign rd_nc = burst_cycles(st_q.rd_chop);
  assign wr_nc = burst_cycles(st_q.wr_chop);
  assign rd_j = st_q.rd_cnt - CL;
  assign wr_je = st_q.wr_cnt - (CWL - 4'h1);
  assign wr_jo = st_q.wr_cnt - CWL;

  // Read: one preamble cycle, then one even and one odd beat per clock.
  assign rd_pre = st_q.rd_busy && (st_q.rd_cnt == CL - 4'h1);
  assign rd_data = st_q.rd_busy && (st_q.rd_cnt >= CL) && (rd_j < rd_nc);

  // Write: even beat on the rising edge, odd beat from the falling edge before.
  assign wr_even_en = st_q.wr_busy && (st_q.wr_cnt >= CWL - 4'h1) && (wr_je < wr_nc);
  assign wr_odd_en = st_q.wr_busy && (st_q.wr_cnt >= CWL) && (wr_jo < wr_nc);

  assign rd_idx_e = mem_idx(st_q.rd_ba, st_q.row[st_q.rd_ba], st_q.rd_col,
                            {rd_j[1:0], 1'b0}, st_q.rd_chop);
  assign rd_idx_o = mem_idx(st_q.rd_ba, st_q.row[st_q.rd_ba], st_q.rd_col,
                            {rd_j[1:0], 1'b1}, st_q.rd_chop);
  assign wr_idx_e = mem_idx(st_q.wr_ba, st_q.row[st_q.wr_ba], st_q.wr_col,
                            {wr_je[1:0], 1'b0}, st_q.wr_chop);
  assign wr_idx_o = mem_idx(st_q.wr_ba, st_q.row[st_q.wr_ba], st_q.wr_col,
                            {wr_jo[1:0], 1'b1}, st_q.wr_chop);

  always_comb begin
    st_d = st_q;
    if (st_q.rd_busy) begin
      st_d.rd_cnt = st_q.rd_cnt + 4'h1;
      if (st_q.rd_cnt == CL + rd_nc - 4'h1) begin
        st_d.rd_busy = 1'b0;
        if (st_q.rd_ap) begin
          st_d.open[st_q.rd_ba] = 1'b0;
        end
      end
    end
    if (st_q.wr_busy) begin
      st_d.wr_cnt = st_q.wr_cnt + 4'h1;
      if (st_q.wr_cnt == CWL + wr_nc - 4'h1) begin
        st_d.wr_busy = 1'b0;
        if (st_q.wr_ap) begin
          st_d.open[st_q.wr_ba] = 1'b0;
        end
      end
    end
    // Commands are taken on every rising link clock edge while clock enable is high.
    case (LINK.cmd)
      dsac_pkg::CMD_MRS: begin
        st_d.mr[LINK.ba[1:0]] = LINK.addr;
      end
      dsac_pkg::CMD_ACT: begin
        st_d.open[LINK.ba] = 1'b1;
        st_d.row[LINK.ba] = LINK.addr[ROW_W-1:0];
      end
      dsac_pkg::CMD_PRE: begin
        if (LINK.addr[dsac_pkg::AP_BIT]) begin
          st_d.open = '0;
        end else begin
          st_d.open[LINK.ba] = 1'b0;
        end
      end
      dsac_pkg::CMD_RD: begin
        // An access to a closed bank is ignored.
        if (st_q.open[LINK.ba]) begin
          st_d.rd_busy = 1'b1;
          st_d.rd_cnt = 4'h0;
          st_d.rd_ba = LINK.ba;
          st_d.rd_col = LINK.addr[COL_KEEP-1:0];
          st_d.rd_chop = chop_sel;
          st_d.rd_ap = LINK.addr[dsac_pkg::AP_BIT];
        end
      end
      dsac_pkg::CMD_WR: begin
        if (st_q.open[LINK.ba]) begin
          st_d.wr_busy = 1'b1;
          st_d.wr_cnt = 4'h0;
          st_d.wr_ba = LINK.ba;
          st_d.wr_col = LINK.addr[COL_KEEP-1:0];
          st_d.wr_chop = chop_sel;
          st_d.wr_ap = LINK.addr[dsac_pkg::AP_BIT];
        end
      end
      default: begin
      end
    endcase
  end

  // Clock enable low from the controller freezes the state, the falling-edge capture and the array writes; the reset release and bank-state crossing run on.
  always_ff @(posedge LINK.ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st_q <= '0;
    end else if (LINK.cke) begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data path, two words per link clock.

  // The odd beat is held half a clock so both beats land on the rising edge.
  always_ff @(negedge LINK.ck) begin
    if (LINK.cke) begin
      dq_neg_q <= LINK.dq;
    end
  end

  always_ff @(posedge LINK.ck) begin
    if (LINK.cke) begin
      if (wr_even_en) begin
        mem_q[wr_idx_e] <= LINK.dq;
      end
      if (wr_odd_en) begin
        mem_q[wr_idx_o] <= dq_neg_q;
      end
    end
  end

  // Read beats switch on clock edges and the strobe copies the clock, so the
  // strobe is edge-aligned; this costs a clock-steered mux at the pins.
  assign LINK.dq_d = LINK.ck ? mem_q[rd_idx_e] : mem_q[rd_idx_o];
  assign LINK.dq_oe_n_d = ~rd_data;
  assign LINK.dqs_d = rd_data & LINK.ck;
  assign LINK.dqs_oe_n_d = ~(rd_pre | rd_data);

  //////////////////////////////////////////////////////////////////////////////
  // Bank state handed to the reference clock domain.

  logic [dsac_pkg::NBANK-1:0] open_s1_q;
  logic [dsac_pkg::NBANK-1:0] open_s2_q;

  // Each flag is an independent level, so a plain two-stage crossing suffices.
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      open_s1_q <= '0;
      open_s2_q <= '0;
    end else if (CLK_EN_IN) begin
      open_s1_q <= st_q.open;
      open_s2_q <= open_s1_q;
    end
  end

  assign BANK_OPEN_OUT = open_s2_q;

endmodule : dsac_mem_dev

// ### sim/dsac_link_props.sv
// Concurrent checks on the link between the controller end and the memory end.
`timescale 1ns/1ns
module dsac_link_props (
  input wire logic RST_N_IN,
  input wire logic ck,
  input wire logic cke,
  input wire dsac_pkg::dsac_cmd_t cmd,
  input wire logic [dsac_pkg::BA_W-1:0] ba,
  input wire logic [dsac_pkg::ADDR_W-1:0] addr,
  input wire logic dq_oe_n_h,
  input wire logic dq_oe_n_d,
  input wire logic dqs_oe_n_h,
  input wire logic dqs_oe_n_d,
  input wire logic dqs
);
  default clocking cb @(posedge ck); endclocking
  default disable iff (!RST_N_IN);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] open_q;
  logic [1:0] init_q;
  logic [2:0] wcnt_q;
  logic wchop_q;
  logic rd;
  logic wr;
  logic busy;
  assign rd = cke && cmd == dsac_pkg::CMD_RD;
  assign wr = cke && cmd == dsac_pkg::CMD_WR;
  assign busy = cke && cmd != dsac_pkg::CMD_NOP && cmd != dsac_pkg::CMD_DES;
  // The write window spans whole link periods, so counting at the link edge is exact.
  always_ff @(posedge ck or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      open_q <= 8'h00;
      init_q <= 2'h0;
      wcnt_q <= 3'h0;
      wchop_q <= 1'b0;
    end else begin
      if (busy && init_q != 2'h2) init_q <= init_q + 2'h1;
      if (cke && cmd == dsac_pkg::CMD_ACT) open_q[ba] <= 1'b1;
      if (cke && cmd == dsac_pkg::CMD_PRE) open_q <= addr[10] ? 8'h00 : open_q & ~(8'h01 << ba);
      if (wr) wchop_q <= !addr[12];
      wcnt_q <= dq_oe_n_h ? 3'h0 : wcnt_q + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence rd_pre_s;
    !dqs_oe_n_d && !dqs;
  endsequence
  sequence rd_data8_s;
    !dqs_oe_n_d [*4] ##1 dqs_oe_n_d;
  endsequence
  sequence rd_data4_s;
    !dqs_oe_n_d [*2] ##1 dqs_oe_n_d;
  endsequence
  no_clash_a: assert property (dq_oe_n_h || dq_oe_n_d)
    else $error("both ends drive the data lines");
  rd_strobe_a: assert property (!dq_oe_n_d |-> !dqs_oe_n_d)
    else $error("read data without memory strobe");
  rd_burst8_a: assert property (rd && addr[12] |-> ##3 rd_pre_s ##1 rd_data8_s)
    else $error("eight beat read window wrong");
  rd_burst4_a: assert property (rd && !addr[12] |-> ##3 rd_pre_s ##1 rd_data4_s)
    else $error("four beat read window wrong");
  wr_drive_a: assert property (wr |-> ##[1:3] (!dq_oe_n_h && !dqs_oe_n_h))
    else $error("write data not driven in time");
  wr_quiet_a: assert property (wr |-> dq_oe_n_d [*4])
    else $error("memory drives during a write");
  wr_len_a: assert property (wcnt_q != 3'h0 && dq_oe_n_h |->
                             wcnt_q == (wchop_q ? 3'h2 : 3'h4))
    else $error("write burst length wrong");
  act_first_a: assert property (rd || wr |-> open_q[ba])
    else $error("access to a bank without a row open");
  init_mrs_a: assert property (busy && init_q == 2'h0 |-> cmd == dsac_pkg::CMD_MRS && ba == 3'h0)
    else $error("first command is not a mode load of register zero");
endmodule : dsac_link_props

// ### sim/ddr3_sdram_access_core_test.sv
// Self-checking bench: controller end and memory end joined over one link.
`timescale 1ns/1ns
module ddr3_sdram_access_core_test;
  logic clk;
  logic rst_n;
  logic req_valid;
  logic req_write;
  logic [2:0] req_bank;
  logic [14:0] req_row;
  logic [9:0] req_col;
  logic req_chop;
  logic req_ap;
  logic [63:0] req_wdata;
  logic [1:0] grade;
  logic [7:0] temp;
  logic ready;
  logic rd_valid;
  logic [63:0] rd_data;
  logic [3:0] mult;
  logic htsr;
  logic sr_ok;
  logic [7:0] bank_open;
  logic [7:0] ref_mem [256];
  logic [7:0] temps [8] = '{8'h00, 8'h55, 8'h56, 8'h69, 8'h6A, 8'h73, 8'h74, 8'hFF};
  int num_errors = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////////////////////////
  dsac_link_if link ();
  // A short refresh interval keeps refresh traffic inside a short run.
  dsac_ctrl_host #(.REFI_TICKS(8)) dsac_ctrl_host_i (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(1'b1), .REQ_VALID_IN(req_valid),
    .REQ_WRITE_IN(req_write), .REQ_BANK_IN(req_bank), .REQ_ROW_IN(req_row),
    .REQ_COL_IN(req_col), .REQ_CHOP_IN(req_chop), .REQ_AP_IN(req_ap),
    .REQ_WDATA_IN(req_wdata), .TEMP_GRADE_IN(grade), .TEMP_C_IN(temp),
    .REQ_READY_OUT(ready), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data),
    .REF_MULT_OUT(mult), .HI_TEMP_SR_OUT(htsr), .SELF_REF_OK_OUT(sr_ok), .LINK(link));
  dsac_mem_dev dsac_mem_dev_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(1'b1),
    .LINK(link), .BANK_OPEN_OUT(bank_open));
  dsac_link_props dsac_link_props_i (.RST_N_IN(rst_n), .ck(link.ck), .cke(link.cke),
    .cmd(link.cmd), .ba(link.ba), .addr(link.addr), .dq_oe_n_h(link.dq_oe_n_h),
    .dq_oe_n_d(link.dq_oe_n_d), .dqs_oe_n_h(link.dqs_oe_n_h),
    .dqs_oe_n_d(link.dqs_oe_n_d), .dqs(link.dqs));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] mem_idx(input logic [2:0] b, input logic r0,
                                         input logic [9:0] c, input int i, input logic chop);
    logic [2:0] s;
    s = c[2:0] + 3'(i);
    if (chop) s[2] = c[2];
    return {b, r0, c[3], s};
  endfunction : mem_idx
  function automatic logic [5:0] temp_exp(input logic [1:0] g, input logic [7:0] t);
    logic [3:0] m;
    m = (t > 8'h55) ? 4'h2 : 4'h1;
    if (g == 2'h2 && t > 8'h69) m = 4'h4;
    if (g == 2'h2 && t > 8'h73) m = 4'h8;
    return {m, g == 2'h0 && t > 8'h55, !(g == 2'h2 && t > 8'h69)};
  endfunction : temp_exp
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // One request, whole; a read waits for its pulse and compares the beats it moved.
  task automatic req(input logic w, input logic [2:0] b, input logic [14:0] r,
                     input logic [9:0] c, input logic chop, input logic ap);
    logic [63:0] d;
    logic [63:0] e;
    int n;
    d = {$urandom, $urandom};
    e = 64'h0;
    n = 0;
    while (ready !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("ready", 64'h1, {63'h0, ready});
    {req_valid, req_write, req_bank, req_row, req_col, req_chop, req_ap} = {1'b1, w, b, r, c, chop, ap};
    req_wdata = d;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    for (int i = 0; i < (chop ? 4 : 8); i++) begin
      if (w) ref_mem[mem_idx(b, r[0], c, i, chop)] = d[8*i+:8];
      e[8*i+:8] = ref_mem[mem_idx(b, r[0], c, i, chop)];
    end
    if (w) return;
    n = 0;
    while (rd_valid !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("rd_valid", 64'h1, {63'h0, rd_valid});
    check("rd_data", e, rd_data & (chop ? 64'hFFFFFFFF : '1));
  endtask : req
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 20000);
    num_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h5914));
    {rst_n, req_valid, req_write, req_bank, req_row, req_col, req_chop, req_ap} = '0;
    {req_wdata, grade, temp} = '0;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int g = 0; g < 3; g++) begin
      foreach (temps[k]) begin
        grade = 2'(g);
        temp = temps[k];
        repeat (3) @(posedge clk);
        #1;
        check("temp_outputs", {58'h0, temp_exp(grade, temp)}, {58'h0, mult, htsr, sr_ok});
      end
    end
    temp = 8'h00;
    for (int k = 0; k < 32; k++) begin
      req(1'b1, 3'(k), {14'($urandom), k[3]}, {6'($urandom), k[4], 3'h0}, 1'b0, 1'($urandom));
    end
    req(1'b1, 3'h2, 15'h0, 10'h007, 1'b1, 1'b0);
    repeat (30) @(posedge clk);
    #1;
    check("bank_open", 64'h4, {56'h0, bank_open});
    req(1'b0, 3'h2, 15'h0, 10'h000, 1'b0, 1'b1);
    repeat (40) begin
      req(1'($urandom), 3'($urandom), 15'($urandom), 10'($urandom), 1'($urandom), 1'($urandom));
    end
    repeat (100) @(posedge clk);
    #1;
    check("bank_open", 64'h0, {56'h0, bank_open});
    finish_test();
  end
endmodule : ddr3_sdram_access_core_test
